// File: hdl/nv_cmd_cfg.svh
// Constants of the serial nonvolatile SRAM command block
// What this block does
// - Pin low, enable set: status writes rejected
// - Enable clear: protect pin level ignored
// - Pin falling mid-frame leaves status write alone
// - Latch, block bits and pin decide protection
// - No memory access during save or restore
// - Three address bytes, A16 in first bit0
// - Read data MSB first on falling edges
// - Read address increments, wraps to zero
// - Write needs latch, opcode, address, data
// - Burst write stores at next address, wraps
// - Write completion clears the write latch
// - Save opcode starts a save only with latch set and idle
// - Decode restore, autosave on, autosave off
// - Specials need latch; cleared at frame end
// - Off opcode disables autosave; default on
// - On opcode enables autosave where supported
// - Autosave setting volatile; host saves after
// - Unsupported variant: no change, busy sequence time
// - Save shown on ready flag and busy pin
// - Ready flag high during save or restore
// - Block bits select protected address range
// - Status bits: 7 enable, 3-2 block, 1 latch, 0 ready
`ifndef NV_CMD_CFG_SVH
`define NV_CMD_CFG_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_READ 8'h03
`define OP_WRITE 8'h02
`define OP_SET_LATCH 8'h06
`define OP_SAVE 8'h3c
`define OP_RESTORE 8'h60
`define OP_AS_ON 8'h59
`define OP_AS_OFF 8'h19
// ----------------------------------------
// Address map and protection
// ----------------------------------------
`define ADDR_W 17
`define MEM_WORDS 131072
`define ADDR_TOP 17'h1ffff
`define ADDR_ZERO 17'h00000
`define ADDR_ONE 17'h00001
`define QTR_BASE 17'h18000
`define HALF_BASE 17'h10000
`define BP_QTR 2'h1
`define BP_HALF 2'h2
`define BP_ALL 2'h3
`define BP_RST 2'h0
// ----------------------------------------
// Status layout and framing
// ----------------------------------------
`define SR_PEN_BIT 7
`define SR_BPH_BIT 3
`define SR_BPL_BIT 2
`define SR_WEN_BIT 1
`define SR_RDY_BIT 0
`define BIT_LAST 3'h7
`define BYTE_OP 3'h0
`define BYTE_ADDR_FIRST 3'h1
`define BYTE_ADDR_LAST 3'h3
`define BYTE_DATA 3'h4
// ----------------------------------------
// Timing
// ----------------------------------------
`define CORE_PERIOD_NS 100
`define NS_PER_US 1000
`define STORE_TIME_US 20
`define RESTORE_TIME_US 20
`define SEQ_TIME_US 10
`define CNT_W 24
`define CNT_ZERO 24'h000000
`define CNT_ONE 24'h000001
`define AUTOSAVE_RST 1'b1
`endif

// File: hdl/nv_cmd_pkg.sv
// Types shared by the nonvolatile SRAM command block
package nv_cmd_pkg;
   // One-hot state of the nonvolatile cycle sequencer
   typedef enum logic [3:0] {
      NV_IDLE    = 4'h1,
      NV_SAVE    = 4'h2,
      NV_RESTORE = 4'h4,
      NV_SEQ     = 4'h8
   } nv_state_t;
endpackage

// File: hdl/spi_nv_sram_cmd.sv
// SPI slave command, protection and nonvolatile sequencing logic
`timescale 1ns/10ps
`default_nettype none
`include "nv_cmd_cfg.svh"
module spi_nv_sram_cmd #(
   parameter int STORE_TIME_US = `STORE_TIME_US,
   parameter int RESTORE_TIME_US = `RESTORE_TIME_US,
   parameter int SEQ_TIME_US = `SEQ_TIME_US,
   parameter bit AUTOSAVE_SUPPORTED = 1'b1
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   input wire logic protect_n_i,
   input wire logic protect_pin_enable_i,
   input wire logic block_protect_hi_i,
   input wire logic block_protect_lo_i,
   output logic [7:0] status_o,
   output logic sr_write_blocked_o,
   output logic ready_flag_o,
   output logic hardware_store_busy_pin_n_o,
   output logic autosave_en_o,
   output logic save_start_o,
   output logic restore_start_o
);

   // ----------------------------------------
   // Timing counts
   // ----------------------------------------
   // A busy time is rounded up so the cycle never ends early
   localparam int STORE_CYC = (STORE_TIME_US * `NS_PER_US + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS;
   localparam int REST_CYC = (RESTORE_TIME_US * `NS_PER_US + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS;
   localparam int SEQ_CYC = (SEQ_TIME_US * `NS_PER_US + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS;
   localparam logic [`CNT_W-1:0] STORE_CNT = `CNT_W'((STORE_CYC < 1) ? 1 : STORE_CYC);
   localparam logic [`CNT_W-1:0] REST_CNT = `CNT_W'((REST_CYC < 1) ? 1 : REST_CYC);
   localparam logic [`CNT_W-1:0] SEQ_CNT = `CNT_W'((SEQ_CYC < 1) ? 1 : SEQ_CYC);

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Address falls inside the range chosen by the block bits
   function automatic logic blk_prot(input logic [`ADDR_W-1:0] a, input logic [1:0] bp);
      case (bp)
         `BP_QTR: blk_prot = (a >= `QTR_BASE);
         `BP_HALF: blk_prot = (a >= `HALF_BASE);
         `BP_ALL: blk_prot = 1'b1;
         default: blk_prot = 1'b0;
      endcase
   endfunction

   // Opcode is one of the four nonvolatile specials
   function automatic logic op_special(input logic [7:0] op);
      op_special = (op == `OP_SAVE) || (op == `OP_RESTORE) ||
                   (op == `OP_AS_ON) || (op == `OP_AS_OFF);
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [2:0] bit_cnt_r;
   logic [2:0] byte_cnt_r;
   logic [7:0] sh_r;
   logic [7:0] op_r;
   logic op_done_r;
   logic [`ADDR_W-1:0] addr_r;
   logic [7:0] out_r;
   logic so_r;
   logic [7:0] mem [0:`MEM_WORDS-1];
   logic cs_s1_r, cs_s2_r, cs_s3_r;
   logic wp_s1_r, wp_s2_r;
   logic cfg_wen_r, cfg_busy_r, sr_prot_r;
   logic [1:0] cfg_bp_r;
   logic wen_r;
   logic autosave_r;
   logic save_pls_r, rest_pls_r;
   logic [`CNT_W-1:0] cnt_r;
   nv_cmd_pkg::nv_state_t state_r;
   logic byte_end, addr_end, data_end, addr_phase;
   logic is_rd, is_wr, frame_end, op_ok, nv_start;
   logic [7:0] in_byte;
   logic [`ADDR_W-1:0] addr_full;
   logic [1:0] bp_live;

   // ----------------------------------------
   // Link side: framing on the serial clock
   // ----------------------------------------
   // Byte in progress, with the bit just sampled on this edge
   assign in_byte = {sh_r[6:0], si_i};
   assign addr_full = {addr_r[`ADDR_W-2:0], si_i};
   assign byte_end = (bit_cnt_r == `BIT_LAST);
   assign addr_phase = (byte_cnt_r >= `BYTE_ADDR_FIRST) && (byte_cnt_r <= `BYTE_ADDR_LAST);
   assign addr_end = byte_end && (byte_cnt_r == `BYTE_ADDR_LAST);
   assign data_end = byte_end && (byte_cnt_r == `BYTE_DATA);
   // Snapshots from the core side hold still for the whole frame
   assign is_rd = (op_r == `OP_READ) && !cfg_busy_r;
   assign is_wr = (op_r == `OP_WRITE) && cfg_wen_r && !cfg_busy_r;

   // Bit and byte position; deselect clears them at once
   always_ff @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         bit_cnt_r <= 3'h0;
         byte_cnt_r <= `BYTE_OP;
      end else begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (byte_end && byte_cnt_r != `BYTE_DATA) begin
            byte_cnt_r <= byte_cnt_r + 3'h1;
         end
      end
   end

   // Input shifter; plain data, needs no reset
   always_ff @(posedge sck_i) begin
      sh_r <= in_byte;
   end

   // Opcode capture; kept after deselect so the core can read it
   always_ff @(posedge sck_i) begin
      if (byte_cnt_r == `BYTE_OP && bit_cnt_r == 3'h0) begin
         op_done_r <= 1'b0;
      end
      if (byte_end && byte_cnt_r == `BYTE_OP) begin
         op_r <= in_byte;
         op_done_r <= 1'b1;
      end
   end

   // Address shift, then post-increment; 17-bit sum wraps top to zero
   always_ff @(posedge sck_i) begin
      if (addr_end) begin
         addr_r <= is_rd ? addr_full + `ADDR_ONE : addr_full;
      end else if (addr_phase) begin
         addr_r <= addr_full;
      end else if (data_end && (is_rd || is_wr)) begin
         addr_r <= addr_r + `ADDR_ONE;
      end
   end

   // Array write; protected blocks stay read only
   always_ff @(posedge sck_i) begin
      if (data_end && is_wr && !blk_prot(addr_r, cfg_bp_r)) begin
         mem[addr_r] <= in_byte;
      end
   end

   // Fetch the next read byte one edge before its first bit leaves
   always_ff @(posedge sck_i) begin
      if (addr_end) begin
         out_r <= mem[addr_full];
      end else if (data_end) begin
         out_r <= mem[addr_r];
      end
   end

   // Serial output changes on falling edges, MSB first
   always_ff @(negedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         so_r <= 1'b0;
      end else begin
         so_r <= out_r[`BIT_LAST - bit_cnt_r];
      end
   end

   // Driven only in the data phase of an accepted read; input ignored there
   assign so_o = so_r;
   assign so_oe_o = !cs_n_i && (byte_cnt_r == `BYTE_DATA) && is_rd;

   // ----------------------------------------
   // Core side: synchronisers
   // ----------------------------------------
   // Chip select and protect pin each pass two flops first
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_s3_r <= 1'b1;
         wp_s1_r <= 1'b1;
         wp_s2_r <= 1'b1;
      end else begin
         cs_s1_r <= cs_n_i;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
         wp_s1_r <= protect_n_i;
         wp_s2_r <= wp_s1_r;
      end
   end

   // Deselect edge: sck is quiet, so the opcode flops are stable
   assign frame_end = cs_s2_r && !cs_s3_r;
   assign op_ok = frame_end && op_done_r;
   assign bp_live = {block_protect_hi_i, block_protect_lo_i};

   // ----------------------------------------
   // Core side: frame snapshots
   // ----------------------------------------
   // Updated only while deselected, so a pin change mid-frame is inert
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         cfg_wen_r <= 1'b0;
         cfg_busy_r <= 1'b0;
         cfg_bp_r <= `BP_RST;
         sr_prot_r <= 1'b0;
      end else if (cs_s2_r && cs_s3_r) begin
         cfg_wen_r <= wen_r;
         cfg_busy_r <= (state_r != nv_cmd_pkg::NV_IDLE);
         cfg_bp_r <= bp_live;
         sr_prot_r <= protect_pin_enable_i && !wp_s2_r;
      end
   end

   // ----------------------------------------
   // Core side: write latch
   // ----------------------------------------
   // Set by the latch opcode, cleared once a write or special ends
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         wen_r <= 1'b0;
      end else if (op_ok && op_r == `OP_SET_LATCH) begin
         wen_r <= 1'b1;
      end else if (op_ok && (op_r == `OP_WRITE || op_special(op_r))) begin
         wen_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Core side: nonvolatile sequencer
   // ----------------------------------------
   // Specials run only with the latch set and nothing already busy
   assign nv_start = op_ok && wen_r && op_special(op_r) &&
                     (state_r == nv_cmd_pkg::NV_IDLE);

   // Busy state and its down-counter
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         state_r <= nv_cmd_pkg::NV_IDLE;
         cnt_r <= `CNT_ZERO;
      end else begin
         case (state_r)
            nv_cmd_pkg::NV_IDLE: begin
               if (nv_start && op_r == `OP_SAVE) begin
                  state_r <= nv_cmd_pkg::NV_SAVE;
                  cnt_r <= STORE_CNT;
               end else if (nv_start && op_r == `OP_RESTORE) begin
                  state_r <= nv_cmd_pkg::NV_RESTORE;
                  cnt_r <= REST_CNT;
               end else if (nv_start) begin
                  state_r <= nv_cmd_pkg::NV_SEQ;
                  cnt_r <= SEQ_CNT;
               end
            end
            nv_cmd_pkg::NV_SAVE, nv_cmd_pkg::NV_RESTORE, nv_cmd_pkg::NV_SEQ: begin
               if (cnt_r == `CNT_ONE) begin
                  state_r <= nv_cmd_pkg::NV_IDLE;
                  cnt_r <= `CNT_ZERO;
               end else begin
                  cnt_r <= cnt_r - `CNT_ONE;
               end
            end
            default: begin
               state_r <= nv_cmd_pkg::NV_IDLE;
               cnt_r <= `CNT_ZERO;
            end
         endcase
      end
   end

   // One-cycle kicks to the nonvolatile cells
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         save_pls_r <= 1'b0;
         rest_pls_r <= 1'b0;
      end else begin
         save_pls_r <= nv_start && (op_r == `OP_SAVE);
         rest_pls_r <= nv_start && (op_r == `OP_RESTORE);
      end
   end

   // Autosave setting is volatile; only a later save keeps it
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         autosave_r <= AUTOSAVE_SUPPORTED & `AUTOSAVE_RST;
      end else if (nv_start && AUTOSAVE_SUPPORTED && op_r == `OP_AS_OFF) begin
         autosave_r <= 1'b0;
      end else if (nv_start && AUTOSAVE_SUPPORTED && op_r == `OP_AS_ON) begin
         autosave_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Status image; unused bits read as zero
   always_comb begin
      status_o = 8'h00;
      status_o[`SR_PEN_BIT] = protect_pin_enable_i;
      status_o[`SR_BPH_BIT] = block_protect_hi_i;
      status_o[`SR_BPL_BIT] = block_protect_lo_i;
      status_o[`SR_WEN_BIT] = wen_r;
      status_o[`SR_RDY_BIT] = ready_flag_o;
   end

   // A closed latch also protects the status register
   assign sr_write_blocked_o = sr_prot_r || !cfg_wen_r;
   assign ready_flag_o = (state_r == nv_cmd_pkg::NV_SAVE) ||
                         (state_r == nv_cmd_pkg::NV_RESTORE);
   assign hardware_store_busy_pin_n_o = (state_r != nv_cmd_pkg::NV_SAVE);
   assign autosave_en_o = autosave_r;
   assign save_start_o = save_pls_r;
   assign restore_start_o = rest_pls_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_latch_set: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      op_ok && op_r == `OP_SET_LATCH |=> wen_r && status_o[`SR_WEN_BIT])
      else $error("latch not set by latch opcode");
   a_latch_clear: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      op_ok && (op_r == `OP_WRITE || op_special(op_r)) |=> !wen_r)
      else $error("latch not cleared after write or special");
   a_save_busy: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      nv_start && op_r == `OP_SAVE |=> ready_flag_o && !hardware_store_busy_pin_n_o && save_pls_r
      ##1 !save_pls_r)
      else $error("save not shown on ready flag and busy pin");
   a_no_special: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      op_ok && !wen_r |=> $stable(autosave_r) &&
      ($stable(state_r) || state_r == nv_cmd_pkg::NV_IDLE))
      else $error("special executed with latch clear");
   a_as_off: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      nv_start && op_r == `OP_AS_OFF |=> autosave_en_o == 1'b0 || !AUTOSAVE_SUPPORTED)
      else $error("autosave not disabled");
   a_sr_frozen: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      !cs_s2_r && !cs_s3_r |=> $stable(sr_prot_r))
      else $error("status protection changed during a frame");
   a_sr_block: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      cs_s2_r && cs_s3_r && protect_pin_enable_i && !wp_s2_r |=> sr_write_blocked_o)
      else $error("status write not blocked by protect pin");
   a_sr_pen_off: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      cs_s2_r && cs_s3_r && !protect_pin_enable_i |=> !sr_prot_r)
      else $error("protect pin honoured with enable clear");
   a_rdy_idle: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      state_r == nv_cmd_pkg::NV_IDLE |-> !ready_flag_o && hardware_store_busy_pin_n_o)
      else $error("ready flag set while idle");
   a_read_wrap: assert property (@(posedge sck_i) disable iff (cs_n_i)
      is_rd && ((data_end && addr_r == `ADDR_TOP) || (addr_end && addr_full == `ADDR_TOP))
      |=> addr_r == `ADDR_ZERO)
      else $error("read address did not wrap");
   a_busy_noread: assert property (@(posedge sck_i) disable iff (cs_n_i)
      cfg_busy_r |-> !so_oe_o)
      else $error("serial output driven while busy");
   // Write bursts roll over from the top address as reads do
   a_write_wrap: assert property (@(posedge sck_i) disable iff (cs_n_i)
      data_end && is_wr && addr_r == `ADDR_TOP |=> addr_r == `ADDR_ZERO)
      else $error("write address did not wrap");
   // Setting opcodes keep memory refused without showing the ready flag
   a_seq_busy: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      nv_start && (op_r == `OP_AS_ON || op_r == `OP_AS_OFF) |=>
      state_r == nv_cmd_pkg::NV_SEQ && !ready_flag_o)
      else $error("setting opcode did not hold the device busy");
   // A busy cycle ends exactly when its count runs out
   a_cycle_end: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      state_r != nv_cmd_pkg::NV_IDLE && cnt_r == `CNT_ONE |=> !ready_flag_o &&
      state_r == nv_cmd_pkg::NV_IDLE)
      else $error("busy cycle did not end on count");

   // Main scenarios the bench must reach
   c_save: cover property (@(posedge core_clk_i) disable iff (!nrst_i) nv_start && op_r == `OP_SAVE);
   c_setting: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
      nv_start && op_r == `OP_AS_OFF);
   c_restore: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
      nv_start && op_r == `OP_RESTORE);
   c_read: cover property (@(posedge sck_i) disable iff (cs_n_i) data_end && is_rd);
   c_write: cover property (@(posedge sck_i) disable iff (cs_n_i) data_end && is_wr);

endmodule // spi_nv_sram_cmd
`default_nettype wire

// File: sim/spi_host_model.sv
// Host SPI master model that sends mode 0 frames to the command block
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o,
   input wire logic so_i
);
   // -----------------------------------
   // Idle levels
   // -----------------------------------
   // Serial clock stands still low outside frames
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end

   // -----------------------------------
   // Frame
   // -----------------------------------
   // Sends the low nbits of tx MSB first and shifts in so on each rising edge
   task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
      int i;
      rx = 64'h0;
      cs_n_o = 1'b0;
      #400; // Select must settle before the first edge
      for (i = nbits - 1; i >= 0; i--) begin
         si_o = tx[i];
         #32 sck_o = 1'b1;
         rx = {rx[62:0], so_i};
         #32 sck_o = 1'b0;
      end
      #32 cs_n_o = 1'b1;
      si_o = ~si_o; // Released line shows no stale value
      #700; // Gap covers the core side frame end decode
   endtask
endmodule // spi_host_model
`default_nettype wire

// File: sim/tb_spi_nv_sram_cmd.sv
// Self-checking bench of the SPI nonvolatile SRAM command block
`timescale 1ns/10ps
`default_nettype none
`include "nv_cmd_cfg.svh"
module tb_spi_nv_sram_cmd;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic sck, cs_n, si, so, so_oe;
   logic protect_n = 1'b1;
   logic pen = 1'b0;
   logic bp_hi = 1'b0;
   logic bp_lo = 1'b0;
   logic [7:0] status;
   logic blocked, ready, busy_n, autosave, save_st, restore_st;
   logic oe_seen = 1'b0;
   logic [63:0] rx;
   logic [16:0] base [1:3] = '{17'h18000, 17'h10000, 17'h00000};
   int errors = 0;
   int cmp_count = 0;
   int save_cnt = 0;
   int rest_cnt = 0;
   int k;

   always #50 core_clk_i = ~core_clk_i;

   spi_nv_sram_cmd #(.STORE_TIME_US(2), .RESTORE_TIME_US(2), .SEQ_TIME_US(1),
      .AUTOSAVE_SUPPORTED(1'b1)) i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
      .protect_n_i(protect_n), .protect_pin_enable_i(pen), .block_protect_hi_i(bp_hi),
      .block_protect_lo_i(bp_lo), .status_o(status), .sr_write_blocked_o(blocked),
      .ready_flag_o(ready), .hardware_store_busy_pin_n_o(busy_n),
      .autosave_en_o(autosave), .save_start_o(save_st), .restore_start_o(restore_st));

   spi_host_model i_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));

   // Pulse counters, since start pulses stand one core cycle only
   always @(posedge core_clk_i) begin
      if (save_st === 1'b1) save_cnt++;
      if (restore_st === 1'b1) rest_cnt++;
   end

   // Remembers whether the output was driven at any rising link edge
   always @(posedge sck) begin
      if (so_oe === 1'b1) oe_seen = 1'b1;
   end

   // -----------------------------------
   // Compare and report
   // -----------------------------------
   task automatic chk1(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %b", $time, what, got);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // -----------------------------------
   // Access tasks
   // -----------------------------------
   task automatic cmd(input logic [7:0] op);
      i_host.frame({56'h0, op}, 8, rx);
   endtask

   // Writes n bytes from d, first byte in d[15:8] when n is 2
   task automatic wr(input logic [16:0] a, input logic [15:0] d, input int n,
      input logic latch);
      if (latch) cmd(`OP_SET_LATCH);
      // A single byte write sends the low byte of d
      if (n == 2) i_host.frame({16'h0, `OP_WRITE, 7'h7f, a, d}, 48, rx);
      else i_host.frame({24'h0, `OP_WRITE, 7'h7f, a, d[7:0]}, 40, rx);
   endtask

   // Reads n bytes and compares them; the last byte is exp[7:0]
   task automatic rd(input logic [16:0] a, input int n, input logic [15:0] exp);
      oe_seen = 1'b0;
      i_host.frame({16'h0, `OP_READ, 7'h7f, a, 16'h0} >> (8 * (2 - n)), 32 + 8 * n, rx);
      if (n == 2) chk8(rx[15:8], exp[15:8], "first read byte");
      chk8(rx[7:0], exp[7:0], "read byte");
      chk1(oe_seen, 1'b1, "output enable");
   endtask

   // Core side levels change one small delay after a core edge, then sync settles
   task automatic pins(input logic pe, input logic pn, input logic bh, input logic bl);
      @(posedge core_clk_i);
      #1;
      pen = pe;
      protect_n = pn;
      bp_hi = bh;
      bp_lo = bl;
      repeat (4) @(posedge core_clk_i);
      #1;
   endtask

   // Bounded wait for the ready flag
   task automatic wait_rdy(input logic v);
      int n;
      n = 0;
      while (ready !== v && n < 100) begin
         @(posedge core_clk_i);
         n++;
      end
      #1;
      if (ready !== v) begin
         errors++;
         $display("wrong value at %0t: ready wait timed out", $time);
         end_sim;
      end
   endtask

   // -----------------------------------
   // Tests
   // -----------------------------------
   initial begin
      repeat (10) @(posedge core_clk_i);
      #1 nrst_i = 1'b1;
      repeat (4) @(posedge core_clk_i);
      #1;
      chk8(status, 8'h00, "status after reset");
      chk1(blocked, 1'b1, "blocked with latch clear");
      chk1(busy_n, 1'b1, "busy pin idle");
      chk1(autosave, 1'b1, "autosave default");
      $display("test reset done");
      cmd(`OP_SET_LATCH);
      pins(1'b0, 1'b0, 1'b0, 1'b0);
      chk8(status, 8'h02, "latch in status");
      chk1(blocked, 1'b0, "pin ignored");
      pins(1'b1, 1'b0, 1'b0, 1'b0);
      chk1(blocked, 1'b1, "pin protects");
      chk8(status, 8'h82, "enable in status");
      pins(1'b1, 1'b1, 1'b0, 1'b0);
      chk1(blocked, 1'b0, "pin high");
      // Pin falls inside an ignored frame; decision frozen until deselect
      fork
         i_host.frame(64'h0, 16, rx);
         begin
            repeat (5) @(posedge core_clk_i);
            #1 protect_n = 1'b0;
            repeat (6) @(posedge core_clk_i);
            chk1(blocked, 1'b0, "pin falling mid frame");
         end
      join
      chk1(blocked, 1'b1, "pin low after frame");
      pins(1'b0, 1'b1, 1'b0, 1'b0);
      $display("test protect pin done");
      wr(`ADDR_TOP, 16'ha53c, 2, 1'b1);
      chk1(status[`SR_WEN_BIT], 1'b0, "latch after write");
      rd(`ADDR_TOP, 2, 16'ha53c);
      wr(17'h00005, 16'h0011, 1, 1'b1);
      wr(17'h00005, 16'h0077, 1, 1'b0);
      rd(17'h00005, 1, 16'h0011);
      $display("test burst done");
      for (k = 1; k <= 3; k++) begin
         pins(1'b0, 1'b1, 1'b0, 1'b0);
         wr(base[k], {8'h0, 8'(k)}, 1, 1'b1);
         pins(1'b0, 1'b1, k[1], k[0]);
         wr(base[k], 16'h00ff, 1, 1'b1);
         rd(base[k], 1, {8'h0, 8'(k)});
      end
      pins(1'b0, 1'b1, 1'b0, 1'b0);
      $display("test block protect done");
      cmd(`OP_SET_LATCH);
      cmd(`OP_SAVE);
      chk1(ready, 1'b1, "ready during save");
      chk1(busy_n, 1'b0, "busy pin during save");
      chk1(status[`SR_RDY_BIT], 1'b1, "status ready bit");
      chk1(status[`SR_WEN_BIT], 1'b0, "latch after save");
      oe_seen = 1'b0;
      i_host.frame({24'h0, `OP_READ, 32'h0}, 40, rx);
      chk1(oe_seen, 1'b0, "read refused while busy");
      wait_rdy(1'b0);
      chk1(busy_n, 1'b1, "busy pin after save");
      chk1(save_cnt == 1, 1'b1, "one save start");
      cmd(`OP_SAVE);
      chk1(ready, 1'b0, "save without latch");
      $display("test save done");
      cmd(`OP_SET_LATCH);
      cmd(`OP_RESTORE);
      chk1(ready, 1'b1, "ready during restore");
      chk1(busy_n, 1'b1, "busy pin in restore");
      wait_rdy(1'b0);
      chk1(rest_cnt == 1, 1'b1, "one restore start");
      $display("test restore done");
      cmd(`OP_SET_LATCH);
      cmd(`OP_AS_OFF);
      chk1(autosave, 1'b0, "autosave off");
      chk1(ready, 1'b0, "no ready for setting");
      // Setting opcodes still hold the device busy for the sequence time
      oe_seen = 1'b0;
      i_host.frame({24'h0, `OP_READ, 32'h0}, 40, rx);
      chk1(oe_seen, 1'b0, "read refused in sequence");
      repeat (20) @(posedge core_clk_i);
      #1;
      cmd(`OP_SET_LATCH);
      cmd(`OP_AS_ON);
      chk1(autosave, 1'b1, "autosave on");
      repeat (20) @(posedge core_clk_i);
      #1;
      cmd(`OP_AS_OFF);
      chk1(autosave, 1'b1, "off without latch");
      cmd(`OP_SET_LATCH);
      cmd(`OP_SAVE);
      wait_rdy(1'b0);
      chk1(save_cnt == 2, 1'b1, "save after setting");
      $display("test autosave done");
      end_sim;
   end

   // Cuts a hang short
   initial begin
      #2000000;
      errors++;
      $display("wrong value at %0t: run timed out", $time);
      end_sim;
   end
endmodule // tb_spi_nv_sram_cmd
`default_nettype wire
